// ### include/faeo_pkg.sv
package faeo_pkg;

    // Converter geometry.
    localparam int NUM_COMP = 15;
    localparam int RESULT_W = 4;
    localparam int LEVEL_W_DEF = 8;
    localparam int TOP_BIT = 3;
    localparam int SYNC_STAGES = 3;

    // Largest true binary code, seen when no comparator is active.
    localparam logic [RESULT_W-1:0] CODE_FULL = 4'hF;

    // Reset values of the storage.
    localparam logic [RESULT_W-1:0] RESULT_RST = 4'h0;
    localparam logic [NUM_COMP-1:0] SAMPLE_RST = 15'h0000;

    // Timing of the strobe as seen from the 100 MHz logic clock.
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_MAX_MSPS = 25;
    localparam int STROBE_PERIOD_NS = 1000 / STROBE_MAX_MSPS;
    localparam int STROBE_PULSE_MIN_NS = 17;
    localparam int STROBE_PERIOD_CYC = (STROBE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_PULSE_CYC = (STROBE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef logic [NUM_COMP-1:0] faeo_therm_t;
    typedef logic [RESULT_W-1:0] faeo_code_t;

    // Number of active comparators, 0 to 15.
    function automatic faeo_code_t faeo_count(input faeo_therm_t therm);
        faeo_code_t n;
        n = 4'h0;
        for (int k = 0; k < NUM_COMP; k++) begin
            n = n + faeo_code_t'(therm[k]);
        end
        return n;
    endfunction

    // True binary with the two active-low group inversions applied.
    function automatic faeo_code_t faeo_encode(input faeo_therm_t therm,
                                               input logic top_flip_n,
                                               input logic low_flip_n);
        faeo_code_t tb;
        tb = CODE_FULL - faeo_count(therm);
        return {tb[TOP_BIT] ^ ~top_flip_n, tb[TOP_BIT-1:0] ^ {TOP_BIT{~low_flip_n}}};
    endfunction

endpackage

// ### include/faeo_sync_if.sv
`timescale 1ns/1ps
interface faeo_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface

// ### hw/faeo_sync.sv
`timescale 1ns/1ps
module faeo_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_in,
    faeo_sync_if.src filt
);
    import faeo_pkg::*;

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] held;
    wire [W-1:0] disagree;
    wire [W-1:0] next_held;

    if (W < 1) begin : g_bad_width
        $error("faeo_sync needs at least one bit");
    end

    // A bit moves only when the last two stages agree, so a single-cycle glitch is dropped.
    assign disagree = stage2 ^ stage3;
    assign next_held = (stage3 & ~disagree) | (held & disagree);
    assign filt.level = held;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            held <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            held <= next_held;
        end
    end

endmodule

// ### hw/faeo_top.sv
`timescale 1ns/1ps
module faeo_top #(
    parameter int LEVEL_W = faeo_pkg::LEVEL_W_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [LEVEL_W-1:0] analog_input_level,
    input wire logic sample_strobe,
    input wire logic top_bit_flip_n,
    input wire logic low_bits_flip_n,
    output logic result_bit_top,
    output logic result_bit_second,
    output logic result_bit_third,
    output logic result_bit_bottom
);
    import faeo_pkg::*;

    if (LEVEL_W < RESULT_W || LEVEL_W > 16) begin : g_bad_width
        $error("faeo_top supports level widths from 4 to 16 bits");
    end
    if (STROBE_PERIOD_CYC < 2 * SYNC_STAGES - 2) begin : g_bad_rate
        $error("logic clock too slow for the strobe rate");
    end

    // Threshold of comparator k sits at (k+1)/16 of the digital level range.
    function automatic logic [LEVEL_W-1:0] threshold(input int k);
        return LEVEL_W'((k + 1) << (LEVEL_W - RESULT_W));
    endfunction

    faeo_sync_if #(.W(LEVEL_W)) level_if ();
    faeo_sync_if #(.W(3)) ctrl_if ();

    // The level bits are filtered one by one; a code caught mid-transition can
    // mix old and new bits, which can throw the sample off by as much as the whole range.
    faeo_sync #(.W(LEVEL_W)) u_level_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(analog_input_level),
        .filt(level_if.src)
    );

    faeo_sync #(.W(3)) u_ctrl_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({sample_strobe, top_bit_flip_n, low_bits_flip_n}),
        .filt(ctrl_if.src)
    );

    wire [LEVEL_W-1:0] level_now;
    wire strobe_level;
    wire top_n_now;
    wire low_n_now;
    wire strobe_edge;
    wire faeo_therm_t comp_now;
    faeo_code_t next_result;

    logic strobe_prev;
    logic primed;
    faeo_therm_t sampled;
    faeo_code_t result;

    assign level_now = level_if.level;
    assign strobe_level = ctrl_if.level[2];
    assign top_n_now = ctrl_if.level[1];
    assign low_n_now = ctrl_if.level[0];

    // Comparator array; a level above the top threshold turns all on, one at
    // or below the lowest turns all off, so out-of-range inputs saturate.
    for (genvar k = 0; k < NUM_COMP; k++) begin : g_comp
        assign comp_now[k] = level_now > threshold(k);
    end

    // Only rising edges count; the strobe is the sole timing reference.
    assign strobe_edge = strobe_level & ~strobe_prev;

    // Controls are sampled at the moment of the update; static levels are
    // assumed, so a change is honoured on the next update only.
    assign next_result = faeo_encode(sampled, top_n_now, low_n_now);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobe_prev <= 1'b0;
        end else begin
            strobe_prev <= strobe_level;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sampled <= SAMPLE_RST;
            primed <= 1'b0;
        end else if (strobe_edge) begin
            sampled <= comp_now;
            primed <= 1'b1;
        end
    end

    // The first edge after reset has no earlier sample, so the word stays put.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result <= RESULT_RST;
        end else if (strobe_edge && primed) begin
            result <= next_result;
        end
    end

    assign result_bit_top = result[3];
    assign result_bit_second = result[2];
    assign result_bit_third = result[1];
    assign result_bit_bottom = result[0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_update;
        strobe_edge && primed;
    endsequence

    sequence s_all_on;
        sampled == {NUM_COMP{1'b1}};
    endsequence

    sequence s_all_off;
        sampled == SAMPLE_RST;
    endsequence

    // Sampled patterns and control settings that the coding checks below combine.
    sequence s_one_on;
        sampled == 15'h0001;
    endsequence

    sequence s_half_on;
        sampled == 15'h007F;
    endsequence

    sequence s_fmt_bin;
        top_n_now && low_n_now;
    endsequence

    sequence s_fmt_twos;
        !top_n_now && low_n_now;
    endsequence

    sequence s_fmt_inv_bin;
        !top_n_now && !low_n_now;
    endsequence

    sequence s_fmt_inv_twos;
        top_n_now && !low_n_now;
    endsequence

    // A comparator with a higher threshold is never on while a lower one is off.
    a_therm_shape: assert property (
        (comp_now[NUM_COMP-1:1] & ~comp_now[NUM_COMP-2:0]) == '0
    ) else $error("comparator pattern is not a thermometer");

    a_comp_polarity: assert property (
        (level_now == '1 |-> comp_now == '1) and (level_now == '0 |-> comp_now == '0)
    ) else $error("comparator sense wrong at range ends");

    a_sample_latch: assert property (
        strobe_edge |=> sampled == $past(comp_now)
    ) else $error("sample not taken on strobe edge");

    a_sample_hold: assert property (
        !strobe_edge |=> $stable(sampled)
    ) else $error("sample changed without a strobe edge");

    a_pipe_latency: assert property (
        s_update |=> result == faeo_encode($past(sampled), $past(top_n_now), $past(low_n_now))
    ) else $error("result not loaded from previous sample");

    a_result_hold: assert property (
        !(strobe_edge && primed) |=> $stable(result)
    ) else $error("output word changed between updates");

    a_top_sat: assert property (
        s_update ##0 s_all_on ##0 (top_n_now && low_n_now) |=> result == 4'h0
    ) else $error("top full scale not coded as zero");

    a_bottom_sat: assert property (
        s_update ##0 s_all_off ##0 (top_n_now && low_n_now) |=> result == 4'hF
    ) else $error("bottom full scale not coded as all ones");

    a_twos_top: assert property (
        s_update ##0 s_all_on ##0 (!top_n_now && low_n_now) |=> result == 4'h8
    ) else $error("offset two's complement top code wrong");

    a_twos_inv_bottom: assert property (
        s_update ##0 s_all_off ##0 (top_n_now && !low_n_now) |=> result == 4'h8
    ) else $error("inverted offset two's complement bottom code wrong");

    a_msb_group: assert property (
        s_update |=> result[TOP_BIT] ==
            ($past(CODE_FULL - faeo_count(sampled)) >> TOP_BIT) ^ !$past(top_n_now)
    ) else $error("top bit inversion wrong");

    a_low_group: assert property (
        s_update |=> result[TOP_BIT-1:0] ==
            (($past(CODE_FULL - faeo_count(sampled)) & 4'h7) ^ {1'b0, {3{!$past(low_n_now)}}})
    ) else $error("low bits inversion wrong");

    a_first_edge: assert property (
        strobe_edge && !primed |=> result == $past(result) && primed
    ) else $error("first edge after reset disturbed the output");

    a_edge_single: assert property (
        strobe_edge |=> !strobe_edge
    ) else $error("strobe edge lasted more than one cycle");

    // The remaining corners, one step and mid-scale of every format, so each of
    // the four codings is pinned at four points of its column.
    a_top_inv_bin: assert property (
        s_update ##0 s_all_on ##0 s_fmt_inv_bin |=> result == 4'hF
    ) else $error("inverted binary top code wrong");

    a_top_inv_twos: assert property (
        s_update ##0 s_all_on ##0 s_fmt_inv_twos |=> result == 4'h7
    ) else $error("inverted offset two's complement top code wrong");

    a_bottom_twos: assert property (
        s_update ##0 s_all_off ##0 s_fmt_twos |=> result == 4'h7
    ) else $error("offset two's complement bottom code wrong");

    a_bottom_inv_bin: assert property (
        s_update ##0 s_all_off ##0 s_fmt_inv_bin |=> result == 4'h0
    ) else $error("inverted binary bottom code wrong");

    a_step_bin: assert property (
        s_update ##0 s_one_on ##0 s_fmt_bin |=> result == 4'hE
    ) else $error("binary code one step from bottom wrong");

    a_step_twos: assert property (
        s_update ##0 s_one_on ##0 s_fmt_twos |=> result == 4'h6
    ) else $error("offset two's complement step code wrong");

    a_step_inv_bin: assert property (
        s_update ##0 s_one_on ##0 s_fmt_inv_bin |=> result == 4'h1
    ) else $error("inverted binary step code wrong");

    a_step_inv_twos: assert property (
        s_update ##0 s_one_on ##0 s_fmt_inv_twos |=> result == 4'h9
    ) else $error("inverted offset two's complement step code wrong");

    a_mid_bin: assert property (
        s_update ##0 s_half_on ##0 s_fmt_bin |=> result == 4'h8
    ) else $error("binary mid-scale code wrong");

    a_mid_twos: assert property (
        s_update ##0 s_half_on ##0 s_fmt_twos |=> result == 4'h0
    ) else $error("offset two's complement mid-scale code wrong");

    a_mid_inv_bin: assert property (
        s_update ##0 s_half_on ##0 s_fmt_inv_bin |=> result == 4'h7
    ) else $error("inverted binary mid-scale code wrong");

    a_mid_inv_twos: assert property (
        s_update ##0 s_half_on ##0 s_fmt_inv_twos |=> result == 4'hF
    ) else $error("inverted offset two's complement mid-scale code wrong");

    a_pin_order: assert property (
        s_update ##0 s_all_on ##0 s_fmt_twos |=>
            result_bit_top && !result_bit_second && !result_bit_third && !result_bit_bottom
    ) else $error("result pins out of order");

    a_sat_ranges: assert property (
        (level_now > threshold(NUM_COMP - 1) |-> comp_now == '1) and
        (level_now <= threshold(0) |-> comp_now == '0)
    ) else $error("out-of-range level did not saturate");

    // Just above a threshold its comparator is on and the next one is still off.
    for (genvar k = 0; k < NUM_COMP - 1; k++) begin : g_comp_chk
        a_comp_step: assert property (
            @(posedge clk) disable iff (sys_rst)
            level_now == threshold(k) + LEVEL_W'(1) |-> comp_now[k] && !comp_now[k + 1]
        ) else $error("comparator step misplaced");
    end

    a_prime_first: assert property (
        strobe_edge |=> primed
    ) else $error("strobe edge did not prime the pipeline");

    // Reset is checked with the default disable lifted, since reset is the very
    // condition that would otherwise switch this check off.
    a_reset_word: assert property (
        disable iff (1'b0)
        sys_rst |=> result == RESULT_RST && !primed && sampled == SAMPLE_RST
    ) else $error("reset did not empty the pipeline");

endmodule

// ### dv/faeo_strobe_src.sv
`timescale 1ns/1ps
module faeo_strobe_src (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [3:0] half_cyc,
    input wire logic [1:0] fmt,
    output logic sample_strobe,
    output logic top_bit_flip_n,
    output logic low_bits_flip_n,
    output int rises
);
    logic [3:0] cnt;
    // The strobe stands low between runs; a run always ends after a falling edge.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_strobe <= 1'b0;
            cnt <= 4'h0;
            rises <= 0;
            top_bit_flip_n <= 1'b1;
            low_bits_flip_n <= 1'b1;
        end else if (!run && !sample_strobe) begin
            cnt <= 4'h0;
            top_bit_flip_n <= fmt[1];
            low_bits_flip_n <= fmt[0];
        end else if (cnt == half_cyc - 4'h1) begin
            cnt <= 4'h0;
            sample_strobe <= ~sample_strobe;
            if (!sample_strobe) begin
                rises <= rises + 1;
            end
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ### dv/tb_flash_adc_encode_output.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_flash_adc_encode_output;
    import faeo_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic run = 1'b0;
    logic [3:0] half_cyc = 4'h7;
    logic [1:0] fmt = 2'h3;
    logic [7:0] level = 8'h00;
    logic strobe, top_n, low_n, b3, b2, b1, b0;
    int rises;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'h6796;
    int lv[$];
    faeo_code_t got, shown;
    logic [7:0] tbl [5] = '{8'h00, 8'h10, 8'h11, 8'h80, 8'hFF};
    assign got = {b3, b2, b1, b0};
    always #5 clk = ~clk;
    faeo_top #(.LEVEL_W(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .analog_input_level(level),
        .sample_strobe(strobe), .top_bit_flip_n(top_n), .low_bits_flip_n(low_n),
        .result_bit_top(b3), .result_bit_second(b2), .result_bit_third(b1),
        .result_bit_bottom(b0));
    faeo_strobe_src u_src (.clk(clk), .sys_rst(sys_rst), .run(run), .half_cyc(half_cyc),
        .fmt(fmt), .sample_strobe(strobe), .top_bit_flip_n(top_n),
        .low_bits_flip_n(low_n), .rises(rises));
    // Reference coder: thresholds at k*16, active when the level is strictly above.
    function automatic faeo_code_t enc(input int l);
        int n;
        logic [3:0] t;
        n = 0;
        for (int k = 1; k <= 15; k++) begin
            if (l > k * 16) begin
                n++;
            end
        end
        t = 4'(15 - n);
        return {t[3] ^ ~fmt[1], t[2:0] ^ {3{~fmt[0]}}};
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_rise(input int n);
        int t;
        t = 0;
        while (rises < n && t < 100) begin
            @(posedge clk);
            t++;
        end
        if (t >= 100) begin
            err_total++;
            $display("CHECK FAILED t=%0t strobe rise missing", $time);
        end
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        shown = 4'h0;
        `CHK(got, shown)
        // Each pass holds one format, covering all four codings.
        for (int f = 0; f < 4; f++) begin
            fmt <= f[1:0];
            repeat (3) @(posedge clk);
            run <= 1'b1;
            for (int i = 0; i < 8; i++) begin
                wait_rise(lv.size() + 1);
                `CHK(got, shown)
                lv.push_back(level);
                repeat (7) @(posedge clk);
                if (lv.size() >= 2) begin
                    shown = enc(lv[lv.size() - 2]);
                end
                `CHK(got, shown)
                level <= (i < 5) ? tbl[i] : 8'($random(seed));
                if (i == 7) begin
                    run <= 1'b0;
                end
            end
            repeat (20) @(posedge clk);
        end
        // Maximum rate with a steady level: the word must settle on that level's code.
        level <= 8'hC8;
        half_cyc <= 4'h2;
        repeat (10) @(posedge clk);
        run <= 1'b1;
        wait_rise(lv.size() + 10);
        run <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK(got, enc(200))
        // A reset between runs empties the pipeline; the next edge only primes it.
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        level <= 8'h11;
        @(posedge clk);
        `CHK(got, 4'h0)
        run <= 1'b1;
        wait_rise(2);
        run <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(got, 4'h0)
        repeat (20) @(posedge clk);
        `CHK(got, enc(17))
        end_of_test();
    end
endmodule
